// ### core/pfp_host.sv
/*
 Host controller that drives a parallel page flash through its chip select, output gate,
 write strobe, address and data pins: page loads, protection sequences, identification
 entry and exit, single reads and toggle polling.
 Assumes the flash pins are wired directly and all inputs are synchronous to i_clk.
*/
`timescale 1ns/1ps
`include "pfp_params.svh"

module pfp_host #(
  parameter int unsigned P_BLC_CYC = `PFP_BYTE_LOAD_WINDOW_CYC,
  parameter int unsigned P_TWC_CYC = `PFP_TWC_CYC
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_op_valid,
  input  wire pfp_pkg::pfp_op_t i_op,
  input  wire logic [14:0]     i_op_addr,
  output logic                 o_op_ready,
  input  wire logic            i_wr_valid,
  input  wire logic [7:0]      i_wr_data,
  output logic                 o_wr_ready,
  output logic                 o_rd_valid,
  output logic [7:0]           o_rd_data,
  output logic                 o_done,
  output logic                 o_err,
  output logic                 o_prot,
  output logic                 o_id_mode,
  output logic [14:0]          o_addr,
  output logic [7:0]           o_data,
  output logic                 o_data_oe,
  input  wire logic [7:0]      i_data,
  output logic                 o_ce_n,
  output logic                 o_oe_n,
  output logic                 o_we_n
);
  import pfp_pkg::*;

  localparam logic [3:0]  WP   = 4'(`PFP_TWP_CYC);
  localparam logic [3:0]  WPH  = 4'(`PFP_TWPH_CYC);
  localparam logic [3:0]  ACC  = 4'(`PFP_TACC_CYC);
  localparam logic [3:0]  OEHP = 4'(`PFP_TOEHP_CYC);
  localparam logic [19:0] BLC  = 20'(P_BLC_CYC);
  localparam logic [19:0] TWC  = 20'(P_TWC_CYC);

  pfp_state_t  state;
  pfp_op_t     op;
  logic [8:0]  page;
  logic [5:0]  boff;
  logic [2:0]  idx;
  logic [3:0]  cnt;
  logic [19:0] timer;
  logic        first;
  logic        last_tog;
  logic        full;

  // Number of command words sent before the page load.
  function automatic logic [2:0] seq_len(input pfp_op_t f_op);
    unique case (f_op)
      PFP_OP_SDP_OFF: seq_len = 3'h6;
      PFP_OP_PROG,
      PFP_OP_READ:    seq_len = 3'h0;
      default:        seq_len = 3'h3;
    endcase
  endfunction : seq_len

  // Command word as {address A14..A0, data I/O7..I/O0}.
  function automatic logic [22:0] seq_word(input pfp_op_t f_op, input logic [2:0] f_idx);
    logic [7:0] last;
    last = `PFP_CMD_PROTECT;
    unique case (f_op)
      PFP_OP_ID_ENTRY: last = `PFP_CMD_ID_ENTRY;
      PFP_OP_ID_EXIT:  last = `PFP_CMD_ID_EXIT;
      PFP_OP_SDP_OFF:  last = (f_idx == 3'h2) ? `PFP_CMD_SETUP : `PFP_CMD_UNPROTECT;
      default:         last = `PFP_CMD_PROTECT;
    endcase
    unique case (f_idx)
      3'h0,
      3'h3:    seq_word = {`PFP_UNLOCK_ADDR1, `PFP_UNLOCK_DATA1};
      3'h1,
      3'h4:    seq_word = {`PFP_UNLOCK_ADDR2, `PFP_UNLOCK_DATA2};
      default: seq_word = {`PFP_UNLOCK_ADDR1, last};
    endcase
  endfunction : seq_word

  assign o_op_ready = (state == PFP_S_IDLE);
  assign o_wr_ready = (state == PFP_S_WAITD) && !full;

  // Sequencer, strobe timing and pin drive.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state     <= PFP_S_IDLE;
      op        <= PFP_OP_PROG;
      page      <= 9'h000;
      boff      <= 6'h00;
      idx       <= 3'h0;
      cnt       <= 4'h0;
      timer     <= 20'h00000;
      first     <= 1'b1;
      last_tog  <= 1'b0;
      full      <= 1'b0;
      o_addr    <= 15'h0000;
      o_data    <= 8'h00;
      o_data_oe <= 1'b0;
      o_ce_n    <= 1'b1;
      o_oe_n    <= 1'b1;
      o_we_n    <= 1'b1;
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
      o_done    <= 1'b0;
      o_err     <= 1'b0;
    end
    else
    begin
      o_rd_valid <= 1'b0;
      o_done     <= 1'b0;
      o_err      <= 1'b0;
      unique case (state)
        PFP_S_IDLE:
        begin
          if (i_op_valid)
          begin
            op    <= i_op;
            page  <= i_op_addr[14:`PFP_PAGE_LSB];
            boff  <= 6'h00;
            full  <= 1'b0;
            idx   <= 3'h0;
            cnt   <= 4'h0;
            timer <= 20'h00000;
            o_ce_n <= 1'b0;
            if (i_op == PFP_OP_READ)
            begin
              o_addr <= i_op_addr;
              o_oe_n <= 1'b0;
              state  <= PFP_S_READ;
            end
            else if (seq_len(i_op) != 3'h0)
            begin
              {o_addr, o_data} <= seq_word(i_op, 3'h0);
              o_data_oe <= 1'b1;
              o_we_n    <= 1'b0;
              state     <= PFP_S_SEQ;
            end
            else
            begin
              state <= PFP_S_WAITD;
            end
          end
        end
        PFP_S_SEQ,
        PFP_S_PAGE:
        begin
          o_oe_n <= 1'b1;
          cnt    <= cnt + 4'h1;
          if (cnt == WP - 4'h1)
          begin
            o_we_n <= 1'b1;
          end
          if (cnt == WP + WPH - 4'h1)
          begin
            cnt       <= 4'h0;
            timer     <= 20'h00000;
            o_data_oe <= 1'b0;
            if (state == PFP_S_SEQ)
            begin
              idx <= idx + 3'h1;
              if (idx + 3'h1 < seq_len(op))
              begin
                {o_addr, o_data} <= seq_word(op, idx + 3'h1);
                o_data_oe <= 1'b1;
                o_we_n    <= 1'b0;
              end
              else if (op == PFP_OP_ID_ENTRY || op == PFP_OP_ID_EXIT)
              begin
                o_ce_n <= 1'b1;
                o_done <= 1'b1;
                state  <= PFP_S_IDLE;
              end
              else
              begin
                state <= PFP_S_WAITD;
              end
            end
            else if (boff == 6'(`PFP_PAGE_BYTES - 1))
            begin
              full  <= 1'b1;
              state <= PFP_S_WAITD;
            end
            else
            begin
              boff  <= boff + 6'h01;
              state <= PFP_S_WAITD;
            end
          end
        end
        PFP_S_WAITD:
        begin
          timer <= timer + 20'h00001;
          if (i_wr_valid && !full)
          begin
            o_addr    <= {page, boff};
            o_data    <= i_wr_data;
            o_data_oe <= 1'b1;
            o_we_n    <= 1'b0;
            cnt       <= 4'h0;
            state     <= PFP_S_PAGE;
          end
          else if (timer == BLC - 20'h00001)
          begin
            // The device starts programming on its own; only a plain load may be short.
            o_err  <= !full && (op != PFP_OP_PROG || boff == 6'h00);
            o_addr <= {page, 6'h00};
            o_oe_n <= 1'b0;
            first  <= 1'b1;
            timer  <= 20'h00000;
            cnt    <= 4'h0;
            state  <= PFP_S_POLL_RD;
          end
        end
        PFP_S_POLL_RD,
        PFP_S_POLL_GAP:
        begin
          timer <= timer + 20'h00001;
          cnt   <= cnt + 4'h1;
          if (timer == TWC - 20'h00001)
          begin
            o_oe_n <= 1'b1;
            o_ce_n <= 1'b1;
            o_err  <= 1'b1;
            o_done <= 1'b1;
            state  <= PFP_S_IDLE;
          end
          else if (state == PFP_S_POLL_RD && cnt == ACC - 4'h1)
          begin
            o_oe_n   <= 1'b1;
            cnt      <= 4'h0;
            first    <= 1'b0;
            last_tog <= i_data[`PFP_TOGGLE_POS];
            if (!first && i_data[`PFP_TOGGLE_POS] == last_tog)
            begin
              o_ce_n <= 1'b1;
              o_done <= 1'b1;
              state  <= PFP_S_IDLE;
            end
            else
            begin
              state <= PFP_S_POLL_GAP;
            end
          end
          else if (state == PFP_S_POLL_GAP && cnt == OEHP - 4'h1)
          begin
            o_oe_n <= 1'b0;
            cnt    <= 4'h0;
            state  <= PFP_S_POLL_RD;
          end
        end
        PFP_S_READ:
        begin
          cnt <= cnt + 4'h1;
          if (cnt == ACC - 4'h1)
          begin
            o_rd_data  <= i_data;
            o_rd_valid <= 1'b1;
            o_oe_n     <= 1'b1;
            o_ce_n     <= 1'b1;
            o_done     <= 1'b1;
            state      <= PFP_S_IDLE;
          end
        end
        default:
        begin
          state <= PFP_S_IDLE;
        end
      endcase
    end
  end

  // Mirror of the device's protection and identification modes.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_prot    <= 1'b0;
      o_id_mode <= 1'b0;
    end
    else if (o_done && !o_err)
    begin
      if (op == PFP_OP_SDP_ON)
      begin
        o_prot <= 1'b1;
      end
      if (op == PFP_OP_SDP_OFF)
      begin
        o_prot <= 1'b0;
      end
      if (op == PFP_OP_ID_ENTRY)
      begin
        o_id_mode <= 1'b1;
      end
      if (op == PFP_OP_ID_EXIT)
      begin
        o_id_mode <= 1'b0;
      end
    end
  end

endmodule : pfp_host

// ### core/pfp_params.svh
/*
 Timing counts, command words and pin field positions for the page flash program controller.
 Assumes a 40 MHz controller clock and a flash device reached through plain parallel pins.
*/
// What this block does
// - Each page byte load starts within 150 us of the previous one.
// - Every strobe falling edge of a page load carries the same page address.
// - Output gate stays high while write strobe and chip select are both low.
// - Protection enable or disable sequences are followed by a full 64-byte page; the host also accepts a shorter load and pulses o_err.
// - Protected program keeps a constant page address after the unlock bytes.
// - The first and last toggle poll reads carry no meaningful value.
// - Toggle polling keeps one unchanged address for the whole poll.
// - Command words are data bits 7..0 and address bits 14..0 in hex.
`ifndef PFP_PARAMS_SVH
`define PFP_PARAMS_SVH

`define PFP_CLK_NS        25
`define PFP_TWP_NS        90
`define PFP_TWPH_NS       100
`define PFP_TACC_NS       70
`define PFP_TOEHP_NS      150
`define PFP_BYTE_LOAD_WINDOW_US       150
`define PFP_TWC_MS        10
`define PFP_TWP_CYC       ((`PFP_TWP_NS + `PFP_CLK_NS - 1) / `PFP_CLK_NS)
`define PFP_TWPH_CYC      ((`PFP_TWPH_NS + `PFP_CLK_NS - 1) / `PFP_CLK_NS)
`define PFP_TACC_CYC      ((`PFP_TACC_NS + `PFP_CLK_NS - 1) / `PFP_CLK_NS)
`define PFP_TOEHP_CYC     ((`PFP_TOEHP_NS + `PFP_CLK_NS - 1) / `PFP_CLK_NS)
`define PFP_BYTE_LOAD_WINDOW_CYC      ((`PFP_BYTE_LOAD_WINDOW_US * 1000) / `PFP_CLK_NS)
`define PFP_TWC_CYC       ((`PFP_TWC_MS * 1000000) / `PFP_CLK_NS)

`define PFP_PAGE_BYTES    64
`define PFP_PAGE_LSB      6
`define PFP_TOGGLE_POS    6

`define PFP_UNLOCK_ADDR1  15'h5555
`define PFP_UNLOCK_ADDR2  15'h2AAA
`define PFP_UNLOCK_DATA1  8'hAA
`define PFP_UNLOCK_DATA2  8'h55
`define PFP_CMD_PROTECT   8'hA0
`define PFP_CMD_SETUP     8'h80
`define PFP_CMD_UNPROTECT 8'h20
`define PFP_CMD_ID_ENTRY  8'h90
`define PFP_CMD_ID_EXIT   8'hF0

`endif

// ### core/pfp_pkg.sv
/*
 Types of the page flash program controller: operation codes and sequencer states.
 Assumes nothing of its surroundings.
*/
package pfp_pkg;

  typedef enum logic [2:0] {
    PFP_OP_PROG      = 3'b000,
    PFP_OP_PROT_PROG = 3'b001,
    PFP_OP_SDP_ON    = 3'b010,
    PFP_OP_SDP_OFF   = 3'b011,
    PFP_OP_ID_ENTRY  = 3'b100,
    PFP_OP_ID_EXIT   = 3'b101,
    PFP_OP_READ      = 3'b110
  } pfp_op_t;

  typedef enum logic [2:0] {
    PFP_S_IDLE     = 3'b000,
    PFP_S_SEQ      = 3'b001,
    PFP_S_WAITD    = 3'b010,
    PFP_S_PAGE     = 3'b011,
    PFP_S_POLL_RD  = 3'b100,
    PFP_S_POLL_GAP = 3'b101,
    PFP_S_READ     = 3'b110
  } pfp_state_t;

endpackage : pfp_pkg

// ### verif/pfp_flash_model.sv
/*
 Behavioural page flash: byte loads, command words, page program, toggle bit, identification.
 Assumes strobes that change on the bench clock and a data bus resolved by the bench.
*/
`timescale 1ns/1ps
`include "pfp_params.svh"

module pfp_flash_model #(
  parameter int unsigned P_WIN   = 20,
  parameter int unsigned P_BUSY  = 60,
  parameter logic [7:0]  P_MAKER = 8'h3C, // Arbitrary value.
  parameter logic [7:0]  P_PART  = 8'h6A  // Arbitrary value.
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [14:0] i_addr,
  input  wire logic [7:0]  i_data,
  output logic [7:0]       o_data
);
  localparam logic [22:0] W1 = {`PFP_UNLOCK_ADDR1, `PFP_UNLOCK_DATA1};
  localparam logic [22:0] W2 = {`PFP_UNLOCK_ADDR2, `PFP_UNLOCK_DATA2};
  logic [7:0]  mem [0:32767];
  logic [22:0] wd [0:69];
  logic [14:0] la;
  logic [7:0]  rd;
  logic [7:0]  last = 8'h00;
  logic        pwe, poe, pce, tog, id, prot, nprot;
  int          n, win, busy, s;
  wire         drive = !i_ce_n && !i_oe_n && i_we_n;
  assign rd = busy > 0 ? {1'b0, tog, 6'h00} : id ? (i_addr[0] ? P_PART : P_MAKER) : mem[i_addr];
  assign o_data = drive ? rd : ~last;
  always @(posedge i_clk)
    if (drive)
      last <= rd;
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      {pwe, poe, pce, tog, id, prot, nprot} <= 7'b1110000;
      n <= 0;
      win <= 0;
      busy <= 0;
    end
    else
    begin
      {pwe, poe, pce} <= {i_we_n, i_oe_n, i_ce_n};
      if (busy > 0 && ((poe && !i_oe_n) || (pce && !i_ce_n)))
        tog <= !tog;
      if (busy == 1)
        prot <= nprot;
      if (busy > 0)
        busy <= busy - 1;
      else if (pwe && !i_we_n && !i_ce_n)
        la <= i_addr;
      else if (!pwe && i_we_n && !i_ce_n)
      begin
        if (n == 2 && wd[0] == W1 && wd[1] == W2 && la == `PFP_UNLOCK_ADDR1 &&
            (i_data == `PFP_CMD_ID_ENTRY || i_data == `PFP_CMD_ID_EXIT))
        begin
          id <= i_data == `PFP_CMD_ID_ENTRY;
          n <= 0;
        end
        else
        begin
          wd[n] <= {la, i_data};
          n <= n + 1;
          win <= P_WIN;
        end
      end
      else if (win > 1)
        win <= win - 1;
      else if (win == 1)
      begin
        win <= 0;
        n <= 0;
        s = (n >= 3 && wd[0] == W1 && wd[1] == W2 && wd[2] == {W1[22:8], `PFP_CMD_PROTECT}) ? 3 :
            (n >= 6 && wd[0] == W1 && wd[1] == W2 && wd[2] == {W1[22:8], `PFP_CMD_SETUP} &&
             wd[3] == W1 && wd[4] == W2 && wd[5] == {W1[22:8], `PFP_CMD_UNPROTECT}) ? 6 : 0;
        nprot <= s == 3 ? 1'b1 : s == 6 ? 1'b0 : prot;
        if ((s > 0 || !prot) && n > s)
        begin
          busy <= P_BUSY;
          for (int i = 0; i < `PFP_PAGE_BYTES; i++)
            mem[{la[14:6], i[5:0]}] <= 8'hC3;
          for (int i = s; i < n; i++)
            mem[wd[i][22:8]] <= wd[i][7:0];
        end
      end
    end
  end
endmodule : pfp_flash_model

// ### verif/pfp_host_sva.sv
/*
 Checker of the page flash host pins and user handshakes.
 Assumes it is bound to the host controller.
*/
`timescale 1ns/1ps
`include "pfp_params.svh"

module pfp_host_sva #(
  parameter int unsigned P_BLC_CYC = 40
) (
  input wire logic             i_clk,
  input wire logic             i_rst,
  input wire logic             i_op_valid,
  input wire pfp_pkg::pfp_op_t i_op,
  input wire logic [14:0]      i_op_addr,
  input wire logic             o_op_ready,
  input wire logic             i_wr_valid,
  input wire logic [7:0]       i_wr_data,
  input wire logic             o_wr_ready,
  input wire logic             o_rd_valid,
  input wire logic             o_done,
  input wire logic [14:0]      o_addr,
  input wire logic [7:0]       o_data,
  input wire logic             o_data_oe,
  input wire logic             o_ce_n,
  input wire logic             o_oe_n,
  input wire logic             o_we_n
);
  import pfp_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [8:0] page;
  logic [5:0] offs;
  int         rdy;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      page <= 9'h000;
      offs <= 6'h00;
      rdy  <= 0;
    end
    else
    begin
      if (i_op_valid && o_op_ready)
        page <= i_op_addr[14:6];
      offs <= (i_op_valid && o_op_ready) ? 6'h00 : offs + 6'(i_wr_valid && o_wr_ready);
      rdy  <= o_wr_ready ? rdy + 1 : 0;
    end
  end
  a_oe_during_write: assert property (!o_we_n && !o_ce_n |-> o_oe_n)
    else $error("output gate low during write");
  a_no_bus_fight: assert property (o_data_oe |-> o_oe_n)
    else $error("data driven while output gate low");
  a_page_byte_pins: assert property (i_wr_valid && o_wr_ready |=> !o_we_n && !o_ce_n &&
    o_addr == {page, $past(offs)} && o_data == $past(i_wr_data))
    else $error("page byte pins wrong");
  a_load_gap_bound: assert property (rdy <= P_BLC_CYC + 2)
    else $error("byte wait too long");
  a_strobe_addr_held: assert property ($fell(o_we_n) |=>
    ($stable(o_addr) && !o_we_n)[*3] ##1 o_we_n)
    else $error("write pulse malformed");
  a_cmd_word_hex: assert property ($fell(o_we_n) && o_addr == `PFP_UNLOCK_ADDR2 |->
    o_data == `PFP_UNLOCK_DATA2)
    else $error("second unlock word wrong");
  a_read_walk: assert property (i_op_valid && o_op_ready && i_op == PFP_OP_READ |=>
    ##[0:1] (!o_ce_n && !o_oe_n) ##[2:4] (o_rd_valid && o_done))
    else $error("read access timing wrong");
  a_poll_addr_fixed: assert property (!o_oe_n && $past(!o_oe_n) |-> $stable(o_addr))
    else $error("address moved during read");
endmodule : pfp_host_sva

bind pfp_host pfp_host_sva #(.P_BLC_CYC(P_BLC_CYC)) u_pfp_host_sva (.*);

// ### verif/tb_top.sv
/*
 Self-checking bench of the page flash host controller against a behavioural flash.
 Assumes shortened byte window and poll limit parameters.
*/
`timescale 1ns/1ps

module tb_top;
  import pfp_pkg::*;
  logic        i_clk = 1'b0, i_rst = 1'b1, i_op_valid = 1'b0, i_wr_valid = 1'b0;
  pfp_op_t     i_op = PFP_OP_PROG;
  logic [14:0] i_op_addr = 15'h0000, o_addr;
  logic [7:0]  i_wr_data = 8'h00, o_rd_data, o_data, m_data;
  logic        o_op_ready, o_wr_ready, o_rd_valid, o_done, o_err, o_prot, o_id_mode;
  logic        o_data_oe, o_ce_n, o_oe_n, o_we_n, err;
  wire  [7:0]  i_data = o_data_oe ? o_data : m_data;
  int          n_fail = 0, samples_checked = 0;
  always #12.5 i_clk = ~i_clk;
  pfp_host #(.P_BLC_CYC(40), .P_TWC_CYC(200)) u_pfp_host (.*);
  pfp_flash_model u_pfp_flash_model (.i_clk(i_clk), .i_rst(i_rst), .i_ce_n(o_ce_n),
    .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_addr), .i_data(i_data), .o_data(m_data));
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wait_hi(input int sel, input int lim);
    int c;
    c = 0;
    #1;
    while ((sel == 0 ? o_wr_ready : sel == 1 ? o_rd_valid : o_done) !== 1'b1 && c < lim)
    begin
      @(posedge i_clk);
      #1;
      c++;
      if (o_err === 1'b1)
        err = 1'b1;
    end
  endtask : wait_hi
  task automatic run_op(input pfp_op_t op, input logic [14:0] a, input int n,
                        input logic [7:0] base);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op       <= op;
    err = 1'b0;
    i_op_addr  <= a;
    i_wr_valid <= n > 0;
    i_wr_data  <= base;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    for (int k = 0; k < n; k++)
    begin
      wait_hi(0, 100);
      @(posedge i_clk);
      i_wr_data <= base ^ 8'(k + 1);
    end
    i_wr_valid <= 1'b0;
    wait_hi(2, 3000);
    cmp("done", 8'h01, {7'h00, o_done});
    @(posedge i_clk);
    #1;
  endtask : run_op
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op       <= PFP_OP_READ;
    i_op_addr  <= a;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    wait_hi(1, 20);
    cmp("read data", exp, o_rd_data);
  endtask : rd
  task automatic t_prog;
    cmp("idle strobes", 8'h07, {5'h00, o_ce_n, o_oe_n, o_we_n});
    run_op(PFP_OP_PROG, 15'h0040, 64, 8'h11);
    cmp("prog err", 8'h00, {7'h00, err});
    rd(15'h007F, 8'h2E);
    run_op(PFP_OP_PROG, 15'h0080, 2, 8'h5A);
    rd(15'h0081, 8'h5B);
    run_op(PFP_OP_PROG, 15'h0040, 0, 8'h00);
    cmp("empty err", 8'h01, {7'h00, err});
  endtask : t_prog
  task automatic t_ident;
    run_op(PFP_OP_ID_ENTRY, 15'h0000, 0, 8'h00);
    cmp("id mode", 8'h01, {7'h00, o_id_mode});
    rd(15'h0000, 8'h3C);
    rd(15'h0001, 8'h6A);
    run_op(PFP_OP_ID_EXIT, 15'h0000, 0, 8'h00);
    rd(15'h0040, 8'h11);
    run_op(PFP_OP_ID_ENTRY, 15'h0000, 0, 8'h00);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(15'h0040, 8'h11);
    cmp("id after reset", 8'h00, {7'h00, o_id_mode});
  endtask : t_ident
  task automatic t_protect;
    run_op(PFP_OP_SDP_ON, 15'h00C0, 64, 8'h20);
    cmp("prot on", 8'h01, {7'h00, o_prot});
    rd(15'h00C5, 8'h25);
    run_op(PFP_OP_PROG, 15'h0040, 4, 8'h99);
    rd(15'h0041, 8'h10);
    run_op(PFP_OP_PROT_PROG, 15'h0040, 64, 8'h77);
    rd(15'h0042, 8'h75);
    run_op(PFP_OP_SDP_OFF, 15'h0100, 64, 8'h30);
    cmp("prot off", 8'h00, {7'h00, o_prot});
    run_op(PFP_OP_PROG, 15'h0040, 1, 8'hE7);
    rd(15'h0040, 8'hE7);
  endtask : t_protect
  task automatic tally_and_finish;
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_prog();
    t_ident();
    t_protect();
    tally_and_finish();
  end
  initial
  begin
    #(25 * 30000);
    n_fail++;
    $display("mismatch watchdog expected finish seen timeout");
    tally_and_finish();
  end
endmodule : tb_top
